/* File: cpss_cfg.svh */
// Constants for the card parallel status block: register map and timing.
// Assumes a 100 MHz system clock and word addressing on the register bus.
`ifndef CPSS_CFG_SVH
`define CPSS_CFG_SVH
`define CPSS_ADDR_W 4
`define CPSS_OFF_CTRL 4'h0
`define CPSS_OFF_STATUS 4'h1
`define CPSS_OFF_EVENT 4'h2
`define CPSS_OFF_PORT16 4'h3
`define CPSS_CTRL_RST 32'h0000_0000
`define CPSS_BIT_IOMODE 0
`define CPSS_BIT_ALERT_EN 1
`define CPSS_BIT_IRQ_LEVEL 2
`define CPSS_BIT_WP 3
`define CPSS_BIT_BUSY 4
`define CPSS_BIT_IRQ_REQ 5
`define CPSS_BIT_WAIT_REQ 6
`define CPSS_BIT_RDY_EV 0
`define CPSS_BIT_WP_EV 1
`define CPSS_BIT_IOWR_EV 2
`define CPSS_INIT_NS 1000
`define CPSS_CLK_NS 10
`define CPSS_INIT_CYC ((`CPSS_INIT_NS + `CPSS_CLK_NS - 1) / `CPSS_CLK_NS)
`define CPSS_PULSE_NS 500
`define CPSS_PULSE_CYC (`CPSS_PULSE_NS / `CPSS_CLK_NS)
`define CPSS_UNMAPPED 32'h0000_0000
`endif

/* File: cpss_front.sv */
// Synchronises the host strobes and selects and detects the write edge.
// Assumes all host pins idle high.
`default_nettype none
module cpss_front (
    input wire logic clk,
    input wire logic reset,
    input wire logic [6:0] pins_n,
    cpss_sync_if.src sy
);
    logic [6:0] sync_q;
    logic iowr_prev;
    // One synchroniser per host strobe
    for (genvar i = 0; i < 7; i++)
    begin : g_sync
        cpss_sync #(.IDLE(1'b1)) u_sync (
            .clk(clk),
            .reset(reset),
            .d(pins_n[i]),
            .q(sync_q[i])
        );
    end
    assign sy.ce_low_n = sync_q[0];
    assign sy.ce_high_n = sync_q[1];
    assign sy.reg_n = sync_q[2];
    assign sy.oe_n = sync_q[3];
    assign sy.we_n = sync_q[4];
    assign sy.iord_n = sync_q[5];
    assign sy.iowr_n = sync_q[6];
    // Trailing edge of the write strobe, seen on synchronised copies only
    always_ff @(posedge clk)
    begin
        if (reset)
            iowr_prev <= 1'b1;
        else
            iowr_prev <= sync_q[6];
    end
    assign sy.iowr_rise = sync_q[6] & ~iowr_prev;
endmodule // cpss_front
`default_nettype wire

/* File: cpss_host.sv */
// Host model for the card pins: selects, space select, strobes and data.
// Assumes callers start from a clock edge; pins change just after edges.
`default_nettype none
module cpss_host (
    input wire logic clk,
    input wire logic wait_n,
    output logic [3:0] sel,
    output logic [3:0] stb_n,
    output logic [15:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: card deselected, common space, all strobes high
    initial
    begin
        sel = 4'hE;
        stb_n = 4'hF;
        data = 16'h0000;
    end
    // Selects settle three edges before the strobe, since the card synchronises them
    task automatic put(input logic [3:0] s, input logic [3:0] st, input logic [15:0] d);
        begin
            @(posedge clk);
            sel <= s;
            data <= d;
            repeat (3) @(posedge clk);
            stb_n <= st;
            repeat (4) @(posedge clk);
            @(negedge clk);
        end
    endtask
    // Never ends a cycle the card is stretching; data turns over once released
    task automatic done;
        begin
            @(posedge clk);
            while (wait_n !== 1'b1) @(posedge clk);
            stb_n <= 4'hF;
            repeat (6) @(posedge clk);
            sel <= 4'hE;
            data <= ~data;
            @(negedge clk);
        end
    endtask
endmodule // cpss_host
`default_nettype wire

/* File: cpss_pkg.sv */
// Types shared by the card parallel status block.
// Assumes the config header supplies all numbers.
`default_nettype none
package cpss_pkg;
    typedef enum logic [1:0] {CPSS_ST_INIT, CPSS_ST_READY} cpss_init_e;
    typedef enum logic [1:0] {CPSS_CYC_IDLE, CPSS_CYC_MEM, CPSS_CYC_IORD, CPSS_CYC_IOWR} cpss_cyc_e;
endpackage
`default_nettype wire

/* File: cpss_sync.sv */
// Two-stage synchroniser for one bit, reset to a given idle level.
// Assumes the input is asynchronous to CLK.
`default_nettype none
module cpss_sync #(
    parameter logic IDLE = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);
    logic stage1;
    // First stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= IDLE;
            q <= IDLE;
        end
        else
        begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule // cpss_sync
`default_nettype wire

/* File: cpss_sync_if.sv */
// Interface carrying synchronised host strobes between block modules.
// Assumes one clock domain on the receiving side.
`default_nettype none
interface cpss_sync_if;
    logic ce_low_n;
    logic ce_high_n;
    logic reg_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic iowr_rise;
    modport src (output ce_low_n, ce_high_n, reg_n, oe_n, we_n, iord_n, iowr_n, iowr_rise);
    modport dst (input ce_low_n, ce_high_n, reg_n, oe_n, we_n, iord_n, iowr_n, iowr_rise);
endinterface
`default_nettype wire

/* File: cpss_top.sv */
// Card-side status and handshake logic of the parallel host interface.
// Assumes Avalon-MM master on CLK; host pins are asynchronous.
// Notes on behaviour
// - Memory mode: status change held high.
// - I/O mode: status change low on ready or write-protect change, if enabled.
// - Space select high means common memory, low attribute memory.
// - Input acknowledge low only while selected in an I/O read.
// - Memory mode: 16-bit output low after reset initialisation.
// - I/O mode: 16-bit output low when addressed port allows wide transfer.
// - Wait may be driven low to stretch any cycle.
// - High select takes odd byte; low select byte by address bit zero.
// - I/O writes are captured on the strobe's trailing edge.
// - Memory mode: ready line low until initialisation done.
// - I/O mode: ready line becomes interrupt, pulse or level.
`include "cpss_cfg.svh"
`default_nettype none
module cpss_top #(
    parameter int INIT_CYC = `CPSS_INIT_CYC,
    parameter int PULSE_CYC = `CPSS_PULSE_CYC
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CHIP_SEL_LOW_N,
    input wire logic CHIP_SEL_HIGH_N,
    input wire logic ATTRIBUTE_SPACE_SEL_N,
    input wire logic OE_STROBE_N,
    input wire logic WE_STROBE_N,
    input wire logic IO_READ_STROBE_N,
    input wire logic IO_WRITE_STROBE_N,
    input wire logic ADDRESS_BIT_ZERO,
    input wire logic [15:0] HOST_DATA,
    output logic STATUS_CHANGE_N,
    output logic INPUT_ACK_N,
    output logic PORT_16BIT_N,
    output logic WAIT_N,
    output logic READY_IRQ_N,
    output logic ATTR_ACCESS,
    output logic ODD_BYTE_ACCESS,
    output logic WORD_ACCESS,
    output logic [15:0] IO_WRITE_DATA,
    output logic IO_WRITE_VALID,
    input wire logic [`CPSS_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    cpss_sync_if sy ();
    cpss_pkg::cpss_init_e init_state;
    logic [31:0] ctrl;
    logic [2:0] events;
    logic [15:0] port16_mask;
    logic [15:0] init_cnt;
    logic [15:0] pulse_cnt;
    logic ready_q;
    logic wp_q;
    logic irq_req_q;
    logic acc_done;
    logic [15:0] next_data;
    logic io_mode;
    logic selected;
    logic io_read_active;
    logic [31:0] status_word;
    logic [31:0] next_readdata;
    logic [15:0] data_hold;

    // Synchronise every host strobe and select first
    cpss_front u_front (
        .clk(CLK),
        .reset(RESET),
        .pins_n({IO_WRITE_STROBE_N, IO_READ_STROBE_N, WE_STROBE_N, OE_STROBE_N,
                 ATTRIBUTE_SPACE_SEL_N, CHIP_SEL_HIGH_N, CHIP_SEL_LOW_N}),
        .sy(sy)
    );

    assign io_mode = ctrl[`CPSS_BIT_IOMODE];
    assign selected = ~sy.ce_low_n | ~sy.ce_high_n;
    assign io_read_active = io_mode & selected & ~sy.iord_n & ~sy.reg_n;

    // Initialisation counter after reset; ready line busy until it ends
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            init_state <= cpss_pkg::CPSS_ST_INIT;
            init_cnt <= 16'h0000;
        end
        else
        begin
            case (init_state)
                cpss_pkg::CPSS_ST_INIT:
                begin
                    if (init_cnt == 16'(INIT_CYC - 1))
                        init_state <= cpss_pkg::CPSS_ST_READY;
                    else
                        init_cnt <= init_cnt + 16'h0001;
                end
                cpss_pkg::CPSS_ST_READY: init_cnt <= init_cnt;
                default: init_state <= cpss_pkg::CPSS_ST_INIT;
            endcase
        end
    end

    // Register bus: zero-wait write, one-wait read
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl <= `CPSS_CTRL_RST;
            port16_mask <= 16'h0000;
        end
        else if (AVS_WRITE)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (AVS_BYTEENABLE[b] && AVS_ADDRESS == `CPSS_OFF_CTRL)
                    ctrl[b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8];
            end
            // Mask is two bytes wide; its own loop keeps every select in range
            for (int b = 0; b < 2; b++)
            begin
                if (AVS_BYTEENABLE[b] && AVS_ADDRESS == `CPSS_OFF_PORT16)
                    port16_mask[b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8];
            end
        end
    end

    // Read data registered; waitrequest held until data stands
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[0] = (init_state == cpss_pkg::CPSS_ST_READY);
        status_word[1] = selected;
        status_word[2] = ~sy.reg_n;
        status_word[3] = irq_req_q;
        case (AVS_ADDRESS)
            `CPSS_OFF_CTRL: next_readdata = ctrl;
            `CPSS_OFF_STATUS: next_readdata = status_word;
            `CPSS_OFF_EVENT: next_readdata = {29'h0000_0000, events};
            `CPSS_OFF_PORT16: next_readdata = {16'h0000, port16_mask};
            default: next_readdata = `CPSS_UNMAPPED;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            AVS_READDATA <= 32'h0000_0000;
            acc_done <= 1'b0;
        end
        else
        begin
            acc_done <= AVS_READ & ~acc_done;
            if (AVS_READ)
                AVS_READDATA <= next_readdata;
        end
    end
    assign AVS_WAITREQUEST = AVS_READ & ~acc_done;

    // Sticky events; a new event wins over a software clear (write one)
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            events <= 3'h0;
            ready_q <= 1'b0;
            wp_q <= 1'b0;
        end
        else
        begin
            ready_q <= ~ctrl[`CPSS_BIT_BUSY];
            wp_q <= ctrl[`CPSS_BIT_WP];
            for (int i = 0; i < 3; i++)
            begin
                if (AVS_WRITE && AVS_ADDRESS == `CPSS_OFF_EVENT && AVS_BYTEENABLE[0]
                    && AVS_WRITEDATA[i])
                    events[i] <= 1'b0;
            end
            if (io_mode && (ready_q != ~ctrl[`CPSS_BIT_BUSY]))
                events[`CPSS_BIT_RDY_EV] <= 1'b1;
            if (io_mode && (wp_q != ctrl[`CPSS_BIT_WP]))
                events[`CPSS_BIT_WP_EV] <= 1'b1;
            if (io_mode && sy.iowr_rise)
                events[`CPSS_BIT_IOWR_EV] <= 1'b1;
        end
    end

    // Status change: high in memory mode, alert in I/O mode when enabled
    always_ff @(posedge CLK)
    begin
        if (RESET)
            STATUS_CHANGE_N <= 1'b1;
        else if (!io_mode)
            STATUS_CHANGE_N <= 1'b1;
        else
            STATUS_CHANGE_N <= ~(ctrl[`CPSS_BIT_ALERT_EN] &
                                 (events[`CPSS_BIT_RDY_EV] | events[`CPSS_BIT_WP_EV]));
    end

    // Input acknowledge only during a selected I/O read
    always_ff @(posedge CLK)
    begin
        if (RESET)
            INPUT_ACK_N <= 1'b1;
        else
            INPUT_ACK_N <= ~io_read_active;
    end

    // 16-bit port indication by mode
    always_ff @(posedge CLK)
    begin
        if (RESET)
            PORT_16BIT_N <= 1'b1;
        else if (!io_mode)
            PORT_16BIT_N <= (init_state != cpss_pkg::CPSS_ST_READY);
        else
            PORT_16BIT_N <= ~(selected & ~sy.reg_n &
                              port16_mask[{ADDRESS_BIT_ZERO, 3'h0}]);
    end

    // Wait stretches any selected cycle while software requests it
    always_ff @(posedge CLK)
    begin
        if (RESET)
            WAIT_N <= 1'b1;
        else
            WAIT_N <= ~(selected & ctrl[`CPSS_BIT_WAIT_REQ] &
                        (~sy.oe_n | ~sy.we_n | ~sy.iord_n | ~sy.iowr_n));
    end

    // Access decode: space and byte lane
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ATTR_ACCESS <= 1'b0;
            ODD_BYTE_ACCESS <= 1'b0;
            WORD_ACCESS <= 1'b0;
        end
        else
        begin
            ATTR_ACCESS <= ~io_mode & selected & ~sy.reg_n;
            WORD_ACCESS <= ~sy.ce_low_n & ~sy.ce_high_n;
            ODD_BYTE_ACCESS <= (sy.ce_low_n & ~sy.ce_high_n) |
                               (~sy.ce_low_n & sy.ce_high_n & ADDRESS_BIT_ZERO);
        end
    end

    // Host data is sampled while the strobe is low, committed at its rise
    always_ff @(posedge CLK)
    begin
        if (RESET)
            data_hold <= 16'h0000;
        else if (!sy.iowr_n)
            data_hold <= HOST_DATA;
    end
    assign next_data = data_hold;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            IO_WRITE_DATA <= 16'h0000;
            IO_WRITE_VALID <= 1'b0;
        end
        else
        begin
            IO_WRITE_VALID <= io_mode & selected & sy.iowr_rise;
            if (io_mode && selected && sy.iowr_rise)
                IO_WRITE_DATA <= next_data;
        end
    end

    // Interrupt pulse timer; pulse mode ends on its own
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            pulse_cnt <= 16'h0000;
            irq_req_q <= 1'b0;
        end
        else
        begin
            irq_req_q <= ctrl[`CPSS_BIT_IRQ_REQ];
            if (ctrl[`CPSS_BIT_IRQ_REQ] && !irq_req_q)
                pulse_cnt <= 16'(PULSE_CYC);
            else if (pulse_cnt != 16'h0000)
                pulse_cnt <= pulse_cnt - 16'h0001;
        end
    end

    // Ready line: busy flag in memory mode, interrupt in I/O mode
    always_ff @(posedge CLK)
    begin
        if (RESET)
            READY_IRQ_N <= 1'b0;
        else if (init_state != cpss_pkg::CPSS_ST_READY)
            READY_IRQ_N <= 1'b0;
        else if (!io_mode)
            READY_IRQ_N <= ~ctrl[`CPSS_BIT_BUSY];
        else if (ctrl[`CPSS_BIT_IRQ_LEVEL])
            READY_IRQ_N <= ~ctrl[`CPSS_BIT_IRQ_REQ];
        else
            READY_IRQ_N <= (pulse_cnt == 16'h0000);
    end
endmodule // cpss_top
`default_nettype wire

/* File: cpss_top_sva.sv */
// Checker of the card status block; it sees the top module's ports only.
// Assumes register writes enable byte 0 and hold until waitrequest is low.
`include "cpss_cfg.svh"
`default_nettype none
module cpss_top_sva #(parameter int INIT_CYC = 4, parameter int PULSE_CYC = 4) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [`CPSS_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CHIP_SEL_LOW_N,
    input wire logic CHIP_SEL_HIGH_N,
    input wire logic IO_READ_STROBE_N,
    input wire logic IO_WRITE_STROBE_N,
    input wire logic STATUS_CHANGE_N,
    input wire logic INPUT_ACK_N,
    input wire logic PORT_16BIT_N,
    input wire logic READY_IRQ_N,
    input wire logic IO_WRITE_VALID
);
    logic io_mode;
    logic [15:0] cnt;
    default clocking dclk @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // Shadow of the mode bit, taken at the edge where the design takes the write
    always_ff @(posedge CLK)
    begin
        if (RESET)
            io_mode <= 1'b0;
        else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `CPSS_OFF_CTRL)
            io_mode <= AVS_WRITEDATA[`CPSS_BIT_IOMODE];
    end
    // Cycles since reset; saturates so a long run cannot wrap
    always_ff @(posedge CLK)
    begin
        if (RESET)
            cnt <= 16'h0000;
        else if (cnt != 16'hFFFF)
            cnt <= cnt + 16'h0001;
    end
    chk_mem_alert_high: assert property ((!io_mode)[*3] |-> STATUS_CHANGE_N)
        else $error("alert low in memory mode");
    chk_mem_ack_idle: assert property ((!io_mode)[*3] |-> INPUT_ACK_N)
        else $error("acknowledge low in memory mode");
    chk_ack_has_read: assert property ($fell(INPUT_ACK_N) |-> !$past(IO_READ_STROBE_N)
        && !$past(IO_READ_STROBE_N, 2) && !$past(CHIP_SEL_LOW_N && CHIP_SEL_HIGH_N, 2))
        else $error("acknowledge without selected read");
    chk_write_one_pulse: assert property (IO_WRITE_VALID |=> !IO_WRITE_VALID)
        else $error("write pulse longer than one cycle");
    chk_write_after_rise: assert property (IO_WRITE_VALID |-> io_mode
        && $past(IO_WRITE_STROBE_N) && $past(IO_WRITE_STROBE_N, 2))
        else $error("write pulse before strobe rise");
    chk_init_busy: assert property (cnt < INIT_CYC |-> !READY_IRQ_N)
        else $error("ready line high during init");
    chk_mem_port_wide: assert property ((!io_mode)[*3] ##0 (cnt > INIT_CYC + 3)
        |-> !PORT_16BIT_N) else $error("wide port line high after init");
    chk_read_answer: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("read not answered in one cycle");
    chk_write_free: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
        else $error("write stalled");
endmodule // cpss_top_sva
bind cpss_top cpss_top_sva #(.INIT_CYC(INIT_CYC), .PULSE_CYC(PULSE_CYC)) chk (
    .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CHIP_SEL_LOW_N(CHIP_SEL_LOW_N), .CHIP_SEL_HIGH_N(CHIP_SEL_HIGH_N),
    .IO_READ_STROBE_N(IO_READ_STROBE_N), .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N),
    .STATUS_CHANGE_N(STATUS_CHANGE_N), .INPUT_ACK_N(INPUT_ACK_N),
    .PORT_16BIT_N(PORT_16BIT_N), .READY_IRQ_N(READY_IRQ_N), .IO_WRITE_VALID(IO_WRITE_VALID));
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the card status block, driven by the host model.
// Assumes design, checker and host model are compiled first.
`include "cpss_cfg.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT = 4;
    localparam int PULSE = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] avs_rd;
    logic avs_wait;
    logic [3:0] sel;
    logic [3:0] stb;
    logic [15:0] hd;
    logic [15:0] wdat;
    logic [15:0] cap;
    logic sc_n, ack_n, p16_n, wait_n, rdy_n, attr, odd, word, vld;
    int nval = 0;
    int err_total = 0;
    int checks = 0;
    always #5 clk = ~clk;
    cpss_top #(.INIT_CYC(INIT), .PULSE_CYC(PULSE)) uut (
        .CLK(clk), .RESET(reset), .CHIP_SEL_LOW_N(sel[3]), .CHIP_SEL_HIGH_N(sel[2]),
        .ATTRIBUTE_SPACE_SEL_N(sel[1]), .ADDRESS_BIT_ZERO(sel[0]), .OE_STROBE_N(stb[3]),
        .WE_STROBE_N(stb[2]), .IO_READ_STROBE_N(stb[1]), .IO_WRITE_STROBE_N(stb[0]),
        .HOST_DATA(hd), .STATUS_CHANGE_N(sc_n), .INPUT_ACK_N(ack_n), .PORT_16BIT_N(p16_n),
        .WAIT_N(wait_n), .READY_IRQ_N(rdy_n), .ATTR_ACCESS(attr), .ODD_BYTE_ACCESS(odd),
        .WORD_ACCESS(word), .IO_WRITE_DATA(wdat), .IO_WRITE_VALID(vld), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(avs_rd), .AVS_WAITREQUEST(avs_wait));
    cpss_host host (.clk(clk), .wait_n(wait_n), .sel(sel), .stb_n(stb), .data(hd));
    // Count write pulses; a pulse is short, so it is caught at every edge
    always @(posedge clk)
    begin
        if (vld === 1'b1)
        begin
            nval <= nval + 1;
            cap <= wdat;
        end
    end
    task automatic chk(input logic ok, input string msg);
        begin
            checks++;
            if (ok !== 1'b1)
            begin
                err_total++;
                $display("CHECK FAILED %0t %s", $time, msg);
            end
        end
    endtask
    // Request held until waitrequest is seen low at a sampling edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            adr <= a;
            wd <= d;
            rd <= !w;
            wr <= w;
            do
            begin
                @(posedge clk);
            end
            while (avs_wait !== 1'b0);
            rdat = avs_rd;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task automatic gap(input int n);
        begin
            repeat (n) @(posedge clk);
            @(negedge clk);
        end
    endtask
    task automatic t_init;
        begin
            chk(rdy_n === 1'b0 && sc_n === 1'b1, "reset levels");
            gap(INIT + 4);
            chk(rdy_n === 1'b1 && p16_n === 1'b0, "init end");
            bus(1'b0, `CPSS_OFF_STATUS, 32'h0000_0000);
            chk(rdat[0] === 1'b1, "init flag");
            bus(1'b1, 4'hF, 32'hFFFF_FFFF);
            bus(1'b0, 4'hF, 32'h0000_0000);
            chk(rdat === `CPSS_UNMAPPED, "unmapped read");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0018);
            gap(3);
            chk(sc_n === 1'b1 && rdy_n === 1'b0, "busy in memory mode");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0008);
            gap(3);
            chk(sc_n === 1'b1 && rdy_n === 1'b1, "alert in memory mode");
        end
    endtask
    task automatic t_space;
        logic [3:0] s [4] = '{4'h4, 4'h7, 4'h2, 4'hA};
        logic [2:0] e [4] = '{3'h4, 3'h2, 3'h1, 3'h2};
        begin
            foreach (s[i])
            begin
                host.put(s[i], 4'h7, 16'h1234);
                chk({attr, odd, word} === e[i], "space and lane decode");
                host.done();
            end
        end
    endtask
    task automatic t_io;
        int n;
        begin
            bus(1'b1, `CPSS_OFF_PORT16, 32'h0000_0001);
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0001);
            host.put(4'h4, 4'hD, 16'h0000);
            chk(ack_n === 1'b0 && p16_n === 1'b0, "io read even port");
            host.done();
            chk(ack_n === 1'b1, "ack after read");
            host.put(4'h5, 4'hD, 16'h0000);
            chk(p16_n === 1'b1, "odd port narrow");
            host.done();
            n = nval;
            host.put(4'h4, 4'hE, 16'hA55A);
            chk(nval === n, "write before rise");
            host.done();
            chk(nval === n + 1 && cap === 16'hA55A, "io write");
            bus(1'b0, `CPSS_OFF_EVENT, 32'h0000_0000);
            chk(rdat[`CPSS_BIT_IOWR_EV] === 1'b1, "write event flag");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0000);
            host.put(4'h4, 4'hD, 16'h0000);
            chk(ack_n === 1'b1, "ack in memory mode");
            host.done();
        end
    endtask
    task automatic t_alert;
        begin
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0003);
            bus(1'b1, `CPSS_OFF_EVENT, 32'h0000_0007);
            gap(3);
            chk(sc_n === 1'b1, "alert idle");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_000B);
            gap(3);
            chk(sc_n === 1'b0, "alert on protect change");
            bus(1'b1, `CPSS_OFF_EVENT, 32'h0000_0007);
            gap(3);
            chk(sc_n === 1'b1, "alert cleared");
        end
    endtask
    task automatic t_wait;
        begin
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0040);
            host.put(4'h2, 4'h7, 16'h0000);
            chk(wait_n === 1'b0, "cycle stretched");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0000);
            host.done();
            chk(wait_n === 1'b1, "stretch released");
        end
    endtask
    task automatic t_irq;
        int n;
        begin
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0025);
            gap(PULSE + 4);
            chk(rdy_n === 1'b0, "level request held");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0001);
            gap(3);
            chk(rdy_n === 1'b1, "request released");
            bus(1'b1, `CPSS_OFF_CTRL, 32'h0000_0021);
            n = 0;
            repeat (PULSE + 8)
            begin
                @(negedge clk);
                n += (rdy_n === 1'b0);
            end
            chk(n === PULSE, "pulse request");
        end
    endtask
    task automatic complete_run;
        begin
            if (err_total == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Main sequence: five reset cycles, then every scenario in turn
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        t_init;
        t_space;
        t_io;
        t_alert;
        t_wait;
        t_irq;
        complete_run;
    end
    // Watchdog: the whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run;
    end
endmodule // testbench
`default_nettype wire
